// ==== hdl/bank1_sfr_pkg.sv ====
// Constants, register identities and carriers for the bank 1 register map
package bank1_sfr_pkg;
   // APB geometry and program counter widths
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 9;
   localparam int IDX_LSB = 2;
   localparam int PC_W = 13;
   localparam int UPPER_W = 5;
   // Register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_INDIRECT = 9'h080;
   localparam logic [IDX_W-1:0] IDX_OPTION = 9'h081;
   localparam logic [IDX_W-1:0] IDX_PC_LOW = 9'h082;
   localparam logic [IDX_W-1:0] IDX_STATUS = 9'h083;
   localparam logic [IDX_W-1:0] IDX_POINTER = 9'h084;
   localparam logic [IDX_W-1:0] IDX_DIR_A = 9'h085;
   localparam logic [IDX_W-1:0] IDX_DIR_B = 9'h086;
   localparam logic [IDX_W-1:0] IDX_PC_UPPER = 9'h08A;
   localparam logic [IDX_W-1:0] IDX_INTCTL = 9'h08B;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN1 = 9'h08C;
   localparam logic [IDX_W-1:0] IDX_IRQ_EN2 = 9'h08D;
   localparam logic [IDX_W-1:0] IDX_POWER = 9'h08E;
   localparam logic [IDX_W-1:0] IDX_OSC_CTL = 9'h08F;
   localparam logic [IDX_W-1:0] IDX_OSC_TUNE = 9'h090;
   localparam logic [IDX_W-1:0] IDX_PERIOD = 9'h092;
   localparam logic [IDX_W-1:0] IDX_SSP_ADDR = 9'h093;
   localparam logic [IDX_W-1:0] IDX_SSP_STAT = 9'h094;
   localparam logic [IDX_W-1:0] IDX_ADC_LOW = 9'h09E;
   localparam logic [IDX_W-1:0] IDX_ADC_CFG = 9'h09F;
   localparam logic [1:0] BANK_ONE = 2'h1;
   // Implemented (readable) and writable bit masks
   localparam logic [7:0] MASK_ALL = 8'hFF;
   localparam logic [7:0] MASK_NONE = 8'h00;
   localparam logic [7:0] MASK_PC_UPPER = 8'h1F;
   localparam logic [7:0] MASK_STATUS_WR = 8'hE7;
   localparam logic [7:0] MASK_IRQ_EN1 = 8'h4F;
   localparam logic [7:0] MASK_IRQ_EN2 = 8'h10;
   localparam logic [7:0] MASK_POWER = 8'h03;
   localparam logic [7:0] MASK_OSC_RD = 8'h74;
   localparam logic [7:0] MASK_OSC_WR = 8'h70;
   localparam logic [7:0] MASK_OSC_TUNE = 8'h3F;
   localparam logic [7:0] MASK_SSP_WR = 8'hC0;
   localparam logic [7:0] MASK_ADC_CFG = 8'hCF;
   localparam logic [7:0] MASK_RESERVED = 8'h00;
   localparam logic [7:0] DIR_A_FIXED = 8'h20;
   localparam int OSC_STABLE_BIT = 2;
   localparam int TO_BIT = 4;
   localparam int PD_BIT = 3;
   localparam int BROWNOUT_BIT = 0;
   // Reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_ONES = 8'hFF;
   localparam logic [7:0] RST_STATUS = 8'h18;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_ACCESS = 1'b1
   } apb_state_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
   } apb_rsp_s;

   typedef struct packed {
      logic [7:0] option_control;
      logic [7:0] port_a_direction;
      logic [7:0] port_b_direction;
      logic [7:0] interrupt_control;
      logic [7:0] peripheral_irq_enable_1;
      logic [7:0] peripheral_irq_enable_2;
      logic [7:0] oscillator_control;
      logic [7:0] oscillator_tuning;
      logic [7:0] timer_period;
      logic [7:0] serial_slave_address;
      logic [7:0] serial_port_status;
      logic [7:0] converter_config_1;
   } cfg_s;
endpackage

// ==== hdl/bank1_special_register_map.sv ====
// Bank 1 special function registers behind an APB slave
`timescale 1ns/1ns
module bank1_special_register_map (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // APB slave
   input wire bank1_sfr_pkg::apb_req_s apb_req,
   output bank1_sfr_pkg::apb_rsp_s apb_rsp,
   // Indirect data memory path
   input wire logic [7:0] ind_rdata,
   output logic [7:0] ind_addr,
   output logic ind_irp,
   output logic ind_we,
   output logic [7:0] ind_wdata,
   // Program counter
   input wire logic pc_load,
   input wire logic [7:0] pc_load_low,
   input wire logic pc_step,
   output logic [bank1_sfr_pkg::PC_W-1:0] pc_value,
   // Core and peripheral status
   input wire logic wdt_timeout,
   input wire logic sleep_entry,
   input wire logic bor_event,
   input wire logic osc_stable_pin,
   input wire logic [5:0] ssp_flags,
   input wire logic [7:0] adc_result_low,
   // Register contents to the core and peripherals
   output logic [7:0] core_status,
   output bank1_sfr_pkg::cfg_s cfg
);
   import bank1_sfr_pkg::*;

   typedef enum logic [4:0] {
      R_NONE = 5'h00,
      R_INDIRECT = 5'h01,
      R_OPTION = 5'h02,
      R_PC_LOW = 5'h03,
      R_STATUS = 5'h04,
      R_POINTER = 5'h05,
      R_DIR_A = 5'h06,
      R_DIR_B = 5'h07,
      R_PC_UPPER = 5'h08,
      R_INTCTL = 5'h09,
      R_IRQ_EN1 = 5'h0A,
      R_IRQ_EN2 = 5'h0B,
      R_POWER = 5'h0C,
      R_OSC_CTL = 5'h0D,
      R_OSC_TUNE = 5'h0E,
      R_PERIOD = 5'h0F,
      R_SSP_ADDR = 5'h10,
      R_SSP_STAT = 5'h11,
      R_ADC_LOW = 5'h12,
      R_ADC_CFG = 5'h13
   } reg_e;

   // Shared registers match on the in-bank offset only; tuning only in odd banks
   function automatic reg_e decode(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      logic [6:0] off;
      reg_e r;
      idx = addr[IDX_LSB +: IDX_W];
      off = idx[6:0];
      r = R_NONE;
      if (addr[1:0] == 2'h0 && addr[ADDR_W-1] == 1'b0) begin
         if (off == IDX_INDIRECT[6:0]) r = R_INDIRECT;
         else if (off == IDX_PC_LOW[6:0]) r = R_PC_LOW;
         else if (off == IDX_STATUS[6:0]) r = R_STATUS;
         else if (off == IDX_POINTER[6:0]) r = R_POINTER;
         else if (off == IDX_PC_UPPER[6:0]) r = R_PC_UPPER;
         else if (off == IDX_INTCTL[6:0]) r = R_INTCTL;
         else if (off == IDX_OSC_TUNE[6:0] && idx[7]) r = R_OSC_TUNE;
         else if (idx[8:7] == BANK_ONE) begin
            case (idx)
               IDX_OPTION: r = R_OPTION;
               IDX_DIR_A: r = R_DIR_A;
               IDX_DIR_B: r = R_DIR_B;
               IDX_IRQ_EN1: r = R_IRQ_EN1;
               IDX_IRQ_EN2: r = R_IRQ_EN2;
               IDX_POWER: r = R_POWER;
               IDX_OSC_CTL: r = R_OSC_CTL;
               IDX_PERIOD: r = R_PERIOD;
               IDX_SSP_ADDR: r = R_SSP_ADDR;
               IDX_SSP_STAT: r = R_SSP_STAT;
               IDX_ADC_LOW: r = R_ADC_LOW;
               IDX_ADC_CFG: r = R_ADC_CFG;
               default: r = R_NONE;
            endcase
         end
      end
      return r;
   endfunction

   // Merge writable bits only; everything else keeps its stored value
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                        input logic [7:0] wmask);
      return (old & ~wmask) | (wd & wmask);
   endfunction

   apb_state_e state_q;
   apb_state_e state_d;
   logic [7:0] option_q, dir_a_q, dir_b_q, intctl_q, irq_en1_q, irq_en2_q;
   logic [7:0] osc_ctl_q, osc_tune_q, period_q, ssp_addr_q, ssp_stat_q, adc_cfg_q;
   logic [7:0] status_q, pointer_q, pc_upper_q, power_q;
   logic [PC_W-1:0] pc_q;
   logic osc_meta_q, osc_sync_q;
   logic ind_we_q;
   logic [7:0] ind_wdata_q;
   apb_rsp_s rsp_q;
   reg_e sel;
   logic wr_en;
   logic [7:0] wd;
   logic [7:0] rd;

   assign sel = decode(apb_req.paddr);
   assign wd = apb_req.pwdata[7:0];
   // Writes land at the completing access edge only
   assign wr_en = apb_req.psel & apb_req.penable & apb_req.pwrite & rsp_q.pready;

   // One wait-free access cycle after setup; pready comes from a flop
   always_comb begin
      state_d = ST_IDLE;
      case (state_q)
         ST_IDLE: if (apb_req.psel && !apb_req.penable) state_d = ST_ACCESS;
         ST_ACCESS: state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) state_q <= ST_IDLE;
      else state_q <= state_d;
   end

   // Read mux; reserved positions would read stored data, unimplemented ones zero
   always_comb begin
      rd = RST_ZERO;
      case (sel)
         R_INDIRECT: rd = (pointer_q == RST_ZERO) ? RST_ZERO : ind_rdata;
         R_OPTION: rd = option_q;
         R_PC_LOW: rd = pc_q[7:0];
         R_STATUS: rd = status_q;
         R_POINTER: rd = pointer_q;
         R_DIR_A: rd = dir_a_q | DIR_A_FIXED;
         R_DIR_B: rd = dir_b_q;
         R_PC_UPPER: rd = pc_upper_q & MASK_PC_UPPER;
         R_INTCTL: rd = intctl_q;
         R_IRQ_EN1: rd = irq_en1_q & MASK_IRQ_EN1;
         R_IRQ_EN2: rd = irq_en2_q & MASK_IRQ_EN2;
         R_POWER: rd = power_q & MASK_POWER;
         R_OSC_CTL: rd = (osc_ctl_q & MASK_OSC_RD) | (osc_ctl_q & MASK_RESERVED);
         R_OSC_TUNE: rd = osc_tune_q & MASK_OSC_TUNE;
         R_PERIOD: rd = period_q;
         R_SSP_ADDR: rd = ssp_addr_q;
         R_SSP_STAT: rd = ssp_stat_q;
         R_ADC_LOW: rd = adc_result_low;
         R_ADC_CFG: rd = adc_cfg_q & MASK_ADC_CFG;
         default: rd = RST_ZERO;
      endcase
   end

   // Read data captured in setup, so it is valid with pready
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsp_q <= '0;
      end else begin
         rsp_q.pready <= (state_d == ST_ACCESS);
         if (apb_req.psel && !apb_req.penable) begin
            rsp_q.prdata <= apb_req.pwrite ? '0 : {24'h000000, rd};
            rsp_q.pslverr <= apb_req.paddr[ADDR_W-1];
         end
      end
   end

   // Peripheral configuration registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         option_q <= RST_ONES;
         dir_a_q <= RST_ONES;
         dir_b_q <= RST_ONES;
         intctl_q <= RST_ZERO;
         irq_en1_q <= RST_ZERO;
         irq_en2_q <= RST_ZERO;
         osc_tune_q <= RST_ZERO;
         period_q <= RST_ONES;
         ssp_addr_q <= RST_ZERO;
         adc_cfg_q <= RST_ZERO;
      end else if (wr_en) begin
         case (sel)
            R_OPTION: option_q <= wd;
            R_DIR_A: dir_a_q <= merge(dir_a_q, wd, ~DIR_A_FIXED);
            R_DIR_B: dir_b_q <= wd;
            R_INTCTL: intctl_q <= wd;
            R_IRQ_EN1: irq_en1_q <= merge(irq_en1_q, wd, MASK_IRQ_EN1);
            R_IRQ_EN2: irq_en2_q <= merge(irq_en2_q, wd, MASK_IRQ_EN2);
            R_OSC_TUNE: osc_tune_q <= merge(osc_tune_q, wd, MASK_OSC_TUNE);
            R_PERIOD: period_q <= wd;
            R_SSP_ADDR: ssp_addr_q <= wd;
            R_ADC_CFG: adc_cfg_q <= merge(adc_cfg_q, wd, MASK_ADC_CFG);
            default: ;
         endcase
      end
   end

   // Oscillator stable flag comes from another domain
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         osc_meta_q <= 1'b0;
         osc_sync_q <= 1'b0;
      end else begin
         osc_meta_q <= osc_stable_pin;
         osc_sync_q <= osc_meta_q;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         osc_ctl_q <= RST_ZERO;
      end else begin
         if (wr_en && sel == R_OSC_CTL) osc_ctl_q <= merge(osc_ctl_q, wd, MASK_OSC_WR);
         osc_ctl_q[OSC_STABLE_BIT] <= osc_sync_q;
      end
   end

   // Serial status: two mode bits by software, the rest mirror the port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ssp_stat_q <= RST_ZERO;
      end else begin
         if (wr_en && sel == R_SSP_STAT) ssp_stat_q[7:6] <= wd[7:6];
         ssp_stat_q[5:0] <= ssp_flags;
      end
   end

   // Status: timeout and power-down flags are hardware-owned
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status_q <= RST_STATUS;
      end else begin
         if (wr_en && sel == R_STATUS) status_q <= merge(status_q, wd, MASK_STATUS_WR);
         if (wdt_timeout) status_q[TO_BIT] <= 1'b0;
         if (sleep_entry) status_q[PD_BIT] <= 1'b0;
      end
   end

   // Brown-out flag cleared by hardware; hardware wins over a software set
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         power_q <= RST_ZERO;
      end else begin
         if (wr_en && sel == R_POWER) power_q <= merge(power_q, wd, MASK_POWER);
         if (bor_event) power_q[BROWNOUT_BIT] <= 1'b0;
      end
   end

   // Pointer content is undefined after reset; zero is one legal choice
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) pointer_q <= RST_ZERO;
      else if (wr_en && sel == R_POINTER) pointer_q <= wd;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) pc_upper_q <= RST_ZERO;
      else if (wr_en && sel == R_PC_UPPER) pc_upper_q <= wd & MASK_PC_UPPER;
   end

   // Upper counter bits change only by a load through the holding register or a carry from a step
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pc_q <= '0;
      end else if (wr_en && sel == R_PC_LOW) begin
         pc_q <= {pc_upper_q[UPPER_W-1:0], wd};
      end else if (pc_load) begin
         pc_q <= {pc_upper_q[UPPER_W-1:0], pc_load_low};
      end else if (pc_step) begin
         pc_q <= pc_q + 13'h0001;
      end
   end

   // Indirect writes go to data memory, not to a register here
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ind_we_q <= 1'b0;
         ind_wdata_q <= RST_ZERO;
      end else begin
         ind_we_q <= wr_en && sel == R_INDIRECT && pointer_q != RST_ZERO;
         if (wr_en && sel == R_INDIRECT) ind_wdata_q <= wd;
      end
   end

   assign apb_rsp = rsp_q;
   assign ind_addr = pointer_q;
   assign ind_irp = status_q[7];
   assign ind_we = ind_we_q;
   assign ind_wdata = ind_wdata_q;
   assign pc_value = pc_q;
   assign core_status = status_q;
   assign cfg.option_control = option_q;
   assign cfg.port_a_direction = dir_a_q | DIR_A_FIXED;
   assign cfg.port_b_direction = dir_b_q;
   assign cfg.interrupt_control = intctl_q;
   assign cfg.peripheral_irq_enable_1 = irq_en1_q;
   assign cfg.peripheral_irq_enable_2 = irq_en2_q;
   assign cfg.oscillator_control = osc_ctl_q;
   assign cfg.oscillator_tuning = osc_tune_q;
   assign cfg.timer_period = period_q;
   assign cfg.serial_slave_address = ssp_addr_q;
   assign cfg.serial_port_status = ssp_stat_q;
   assign cfg.converter_config_1 = adc_cfg_q;

   // Checks
   sequence setup_read_s;
      apb_req.psel && !apb_req.penable && !apb_req.pwrite;
   endsequence

   sequence core_load_s;
      pc_load && !(wr_en && sel == R_PC_LOW);
   endsequence

   a_hole_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
      setup_read_s and (sel == R_NONE) |=> apb_rsp.prdata == '0)
      else $error("unimplemented address returned nonzero data");

   a_enable_bits_zero: assert property (@(posedge clk) disable iff (!rstn)
      setup_read_s and (sel == R_IRQ_EN1) |=> (apb_rsp.prdata[7:0] & ~MASK_IRQ_EN1) == 8'h00)
      else $error("unimplemented enable bit read nonzero");

   // Hardware-owned flag bits are left out, they may move on their own
   a_hole_no_write: assert property (@(posedge clk) disable iff (!rstn)
      wr_en && sel == R_NONE |=>
      $stable({option_q, dir_a_q, dir_b_q, intctl_q, irq_en1_q, irq_en2_q})
      && $stable({osc_tune_q, period_q, ssp_addr_q, adc_cfg_q, ssp_stat_q[7:6]})
      && $stable({pointer_q, pc_upper_q, osc_ctl_q & MASK_OSC_WR, status_q & MASK_STATUS_WR}))
      else $error("write to unimplemented address changed state");

   a_shared_pointer: assert property (@(posedge clk) disable iff (!rstn)
      wr_en && sel == R_POINTER |=> pointer_q == $past(wd))
      else $error("pointer not written through a mirrored address");

   a_upper_no_direct: assert property (@(posedge clk) disable iff (!rstn)
      !(wr_en && sel == R_PC_LOW) && !pc_load && !pc_step |=> $stable(pc_q))
      else $error("counter changed without a load or step");

   a_load_takes_upper: assert property (@(posedge clk) disable iff (!rstn)
      core_load_s |=> pc_q == {$past(pc_upper_q[UPPER_W-1:0]), $past(pc_load_low)})
      else $error("counter load ignored the holding register");

   a_pin5_reads_one: assert property (@(posedge clk) disable iff (!rstn)
      setup_read_s and (sel == R_DIR_A) |=> apb_rsp.prdata[5] == 1'b1 && cfg.port_a_direction[5])
      else $error("port A pin 5 direction not one");

   a_reset_values: assert property (@(posedge clk)
      $rose(rstn) |-> option_q == RST_ONES && period_q == RST_ONES && status_q == RST_STATUS)
      else $error("register missed its reset value");

   a_pointer_drives: assert property (@(posedge clk) disable iff (!rstn)
      wr_en && sel == R_POINTER ##1 !(wr_en && sel == R_POINTER) |-> ind_addr == $past(wd))
      else $error("indirect address does not follow the pointer");

   a_osc_reserved: assert property (@(posedge clk) disable iff (!rstn)
      setup_read_s and (sel == R_OSC_CTL) |=> (apb_rsp.prdata[7:0] & 8'h8B) == 8'h00)
      else $error("oscillator control unimplemented bit read nonzero");

   a_ready_one_cycle: assert property (@(posedge clk) disable iff (!rstn)
      apb_rsp.pready |=> !apb_rsp.pready)
      else $error("pready held longer than one cycle");
endmodule // bank1_special_register_map

// ==== verification/core_mem_model.sv ====
// Behavioural data memory of the core, reached through the indirect path
`timescale 1ns/1ns
module core_mem_model (
   // Clock
   input wire logic clk,
   // Indirect path from the register map
   input wire logic [7:0] ind_addr,
   input wire logic ind_irp,
   input wire logic ind_we,
   input wire logic [7:0] ind_wdata,
   output logic [7:0] ind_rdata
);
   logic [7:0] mem_q [0:511];

   // Fill of 8'hA5 xor the low address bits so a missed write cannot read back as a match
   initial begin
      for (int i = 0; i < 512; i++) begin
         mem_q[i] = 8'hA5 ^ i[7:0];
      end
   end

   // Pointer plus bank bit selects the byte
   always @(posedge clk) begin
      if (ind_we) begin
         mem_q[{ind_irp, ind_addr}] <= ind_wdata;
      end
   end

   assign ind_rdata = mem_q[{ind_irp, ind_addr}];
endmodule // core_mem_model

// ==== verification/testbench.sv ====
// Self-checking bench for the bank 1 register map over APB
`timescale 1ns/1ns
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   import bank1_sfr_pkg::*;
   logic clk, rstn, ind_irp, ind_we, pc_load, pc_step, wdt_timeout, sleep_entry;
   logic bor_event, osc_stable_pin;
   logic [7:0] ind_rdata, ind_addr, ind_wdata, pc_load_low, adc_result_low, core_status;
   logic [5:0] ssp_flags;
   logic [PC_W-1:0] pc_value;
   apb_req_s req;
   apb_rsp_s rsp;
   cfg_s cfg;
   int err_count, check_count, cycles;
   logic [31:0] rd;
   logic se;

   bank1_special_register_map i_bank1_special_register_map (.clk(clk), .rstn(rstn),
      .apb_req(req), .apb_rsp(rsp), .ind_rdata(ind_rdata), .ind_addr(ind_addr),
      .ind_irp(ind_irp), .ind_we(ind_we), .ind_wdata(ind_wdata), .pc_load(pc_load),
      .pc_load_low(pc_load_low), .pc_step(pc_step), .pc_value(pc_value),
      .wdt_timeout(wdt_timeout), .sleep_entry(sleep_entry), .bor_event(bor_event),
      .osc_stable_pin(osc_stable_pin), .ssp_flags(ssp_flags),
      .adc_result_low(adc_result_low), .core_status(core_status), .cfg(cfg));
   core_mem_model i_core_mem_model (.clk(clk), .ind_addr(ind_addr), .ind_irp(ind_irp),
      .ind_we(ind_we), .ind_wdata(ind_wdata), .ind_rdata(ind_rdata));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   function automatic logic [11:0] ba(input logic [IDX_W-1:0] idx);
      return {1'b0, idx, 2'b00};
   endfunction

   // Setup, then access held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= {24'h000000, d};
      @(posedge clk);
      req.penable <= 1'b1;
      do @(posedge clk); while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      se = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic chk_rd(input logic [11:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      `CHK(rd, {24'h000000, exp})
   endtask

   // One-cycle strobe on {pc_load, pc_step, wdt_timeout, sleep_entry, bor_event}
   task automatic pulse(input logic [4:0] k);
      @(posedge clk);
      {pc_load, pc_step, wdt_timeout, sleep_entry, bor_event} <= k;
      @(posedge clk);
      {pc_load, pc_step, wdt_timeout, sleep_entry, bor_event} <= 5'h00;
      @(negedge clk);
   endtask

   task automatic do_reset;
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
   endtask

   task automatic conclude;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         conclude();
      end
   end

   // Index and expected value after reset, in one word each
   localparam logic [16:0] RST_TAB [15] = '{{IDX_OPTION, 8'hFF}, {IDX_PC_LOW, 8'h00},
      {IDX_STATUS, 8'h18}, {IDX_POINTER, 8'h00}, {IDX_DIR_A, 8'hFF}, {IDX_DIR_B, 8'hFF},
      {IDX_PC_UPPER, 8'h00}, {IDX_IRQ_EN1, 8'h00}, {IDX_IRQ_EN2, 8'h00}, {IDX_OSC_CTL, 8'h00},
      {IDX_OSC_TUNE, 8'h00}, {IDX_PERIOD, 8'hFF}, {IDX_SSP_ADDR, 8'h00},
      {IDX_SSP_STAT, 8'h00}, {IDX_ADC_CFG, 8'h00}};
   // Index and readback after writing all ones
   localparam logic [16:0] MASK_TAB [8] = '{{IDX_IRQ_EN1, 8'h4F}, {IDX_IRQ_EN2, 8'h10},
      {IDX_POWER, 8'h03}, {IDX_OSC_CTL, 8'h70}, {IDX_OSC_TUNE, 8'h3F},
      {IDX_ADC_CFG, 8'hCF}, {IDX_PC_UPPER, 8'h1F}, {IDX_SSP_STAT, 8'hC0}};
   localparam logic [8:0] UNIMP [12] = '{9'h087, 9'h088, 9'h089, 9'h091, 9'h095, 9'h096,
      9'h097, 9'h098, 9'h099, 9'h09A, 9'h09B, 9'h09C};

   initial begin
      rstn = 1'b0;
      req = '0;
      {pc_load, pc_step, wdt_timeout, sleep_entry, bor_event, osc_stable_pin} = '0;
      pc_load_low = 8'h00;
      ssp_flags = 6'h00;
      adc_result_low = 8'hC3;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      foreach (RST_TAB[i]) chk_rd(ba(RST_TAB[i][16:8]), RST_TAB[i][7:0]);
      foreach (UNIMP[i]) apb(1'b1, ba(UNIMP[i]), 8'hFF);
      foreach (UNIMP[i]) chk_rd(ba(UNIMP[i]), 8'h00);
      chk_rd(ba(9'h09D), 8'h00);
      chk_rd(ba(IDX_PERIOD), 8'hFF);
      foreach (MASK_TAB[i]) apb(1'b1, ba(MASK_TAB[i][16:8]), 8'hFF);
      foreach (MASK_TAB[i]) chk_rd(ba(MASK_TAB[i][16:8]), MASK_TAB[i][7:0]);
      apb(1'b1, ba(IDX_DIR_A), 8'h00);
      chk_rd(ba(IDX_DIR_A), 8'h20);
      `CHK(cfg.port_a_direction, 8'h20)
      // Shared registers reach one storage from every bank; tuning is reached from odd banks only
      apb(1'b1, ba(9'h00A), 8'h15);
      chk_rd(ba(IDX_PC_UPPER), 8'h15);
      chk_rd(ba(9'h18A), 8'h15);
      apb(1'b1, ba(9'h190), 8'h2A);
      chk_rd(ba(IDX_OSC_TUNE), 8'h2A);
      chk_rd(ba(9'h010), 8'h00);
      apb(1'b1, ba(IDX_PC_LOW), 8'h34);
      @(negedge clk);
      `CHK(pc_value, 13'h1534)
      chk_rd(ba(IDX_PC_LOW), 8'h34);
      pulse(5'h08);
      `CHK(pc_value, 13'h1535)
      apb(1'b1, ba(IDX_PC_UPPER), 8'hEA);
      pc_load_low <= 8'h56;
      pulse(5'h10);
      `CHK(pc_value, 13'h0A56)
      // Indirect write and read through the pointer
      apb(1'b1, ba(IDX_POINTER), 8'h40);
      chk_rd(ba(IDX_POINTER), 8'h40);
      apb(1'b1, ba(IDX_INDIRECT), 8'h5A);
      chk_rd(ba(9'h180), 8'h5A);
      `CHK(ind_irp, 1'b0)
      // Status bits 4 and 3 belong to hardware
      apb(1'b1, ba(IDX_STATUS), 8'hFF);
      chk_rd(ba(IDX_STATUS), 8'hFF);
      apb(1'b1, ba(9'h103), 8'h00);
      chk_rd(ba(IDX_STATUS), 8'h18);
      pulse(5'h04);
      `CHK(core_status, 8'h08)
      pulse(5'h02);
      `CHK(core_status, 8'h00)
      pulse(5'h01);
      chk_rd(ba(IDX_POWER), 8'h02);
      osc_stable_pin <= 1'b1;
      ssp_flags <= 6'h2A;
      repeat (4) @(posedge clk);
      chk_rd(ba(IDX_OSC_CTL), 8'h74);
      chk_rd(ba(IDX_SSP_STAT), 8'hEA);
      chk_rd(ba(IDX_ADC_LOW), 8'hC3);
      chk_rd(12'h201, 8'h00);
      apb(1'b0, 12'h800, 8'h00);
      `CHK(se, 1'b1)
      apb(1'b1, ba(IDX_OPTION), 8'h00);
      do_reset();
      chk_rd(ba(IDX_OPTION), 8'hFF);
      chk_rd(ba(IDX_PC_UPPER), 8'h00);
      conclude();
   end
endmodule // testbench
